// ===== hdl/apr_pkg.sv
// Purpose: Shared constants and types for the parallel result read-out port
// Assumes: One 10 MHz clock on both ends
// Notes: Times are in ns, cycle counts derived from them
package apr_pkg;
    localparam int RES_W = 18;
    localparam int CLK_PERIOD_NS = 100;
    // Conversion time, longest, rounds down
    localparam int CONV_TIME_NS = 650;
    localparam int CONV_CYC = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
        CONV_TIME_NS / CLK_PERIOD_NS;
    // Quiet zone around the start edge, least times, round up
    localparam int QUIET_PRE_NS = 50;
    localparam int QUIET_PRE_CYC = (QUIET_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUIET_POST_NS = 40;
    localparam int QUIET_POST_CYC = (QUIET_POST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
    localparam logic [CNT_W-1:0] PRE_LOAD = CNT_W'(QUIET_PRE_CYC);
    localparam logic [CNT_W-1:0] POST_LOAD = CNT_W'(QUIET_POST_CYC);
    // Host timing
    localparam logic [CNT_W-1:0] START_LOW_LAST = 3'h0;
    localparam logic [CNT_W-1:0] SLICE_HOLD_LAST = 3'h1;
    // Result codes
    localparam logic [RES_W-1:0] CODE_POS_MAX = 18'h1ffff;
    localparam logic [RES_W-1:0] CODE_ZERO = 18'h00000;
    localparam logic [RES_W-1:0] CODE_NEG_ONE = 18'h3ffff;
    localparam logic [RES_W-1:0] CODE_NEG_MAX = 18'h20000;
    localparam logic [RES_W-1:0] ALL_ONES = 18'h3ffff;
    // Reset values
    localparam logic [RES_W-1:0] RESULT_RST = 18'h00000;
    // Host bus width modes
    typedef enum logic [1:0] {
        APR_W18,
        APR_W16,
        APR_W8
    } apr_width_t;
    typedef enum logic {
        APR_CONV_IDLE,
        APR_CONV_RUN
    } apr_conv_state_t;
    typedef enum logic [2:0] {
        APR_H_IDLE,
        APR_H_GAP,
        APR_H_START,
        APR_H_WAIT_BUSY,
        APR_H_WAIT_DONE,
        APR_H_READ,
        APR_H_TOGGLE,
        APR_H_DONE
    } apr_host_state_t;
endpackage : apr_pkg

// ===== hdl/apr_link_if.sv
// Purpose: Pins between the converter port and its reading host
// Assumes: Result bus per-pin enable is high while the device drives
// Notes: Released pins read low, as with a pull-down
`timescale 1ns/10ps
interface apr_link_if;
    logic chip_select_n;
    logic read_strobe_n;
    logic conversion_start_n;
    logic word_width_select;
    logic middle_slice_select;
    logic busy;
    logic [apr_pkg::RES_W-1:0] result_bus_o;
    logic [apr_pkg::RES_W-1:0] result_bus_oe;
    wire [apr_pkg::RES_W-1:0] result_bus;

    // Pin level from each enable
    for (genvar i = 0; i < apr_pkg::RES_W; i++) begin : g_pin
        assign result_bus[i] = result_bus_oe[i] & result_bus_o[i];
    end

    modport dev (
        input chip_select_n,
        input read_strobe_n,
        input conversion_start_n,
        input word_width_select,
        input middle_slice_select,
        output busy,
        output result_bus_o,
        output result_bus_oe
    );
    modport host (
        output chip_select_n,
        output read_strobe_n,
        output conversion_start_n,
        output word_width_select,
        output middle_slice_select,
        input busy,
        input result_bus
    );
endinterface : apr_link_if

// ===== hdl/apr_host.sv
// Purpose: Host end that starts conversions and reads the result in slices
// Assumes: Device answers one clock after strobe and select changes
// Notes: Each slice is sampled on the second cycle it is presented
//
// What this block does
// - Drive bus only when select and strobe low
// - Two's complement codes, saturated at full scale
// - Host avoids reads around the start edge
// - Both selects low: whole result, same order
// - 16-bit host reads twice, pins 17 to 2
// - Width select: bits 1..0 on pins 3..2
// - Middle select: bits 9..2 on pins 17..10
// - Both selects: bits 1..0 on pins 11..10
// - 8-bit host reads three slices, pins 17..10
// - 8-bit host may skip the third slice
// - Strobe may toggle or stay low per slice
// - Internal conversion done within 650 ns
// - Busy falling edge announces a new result
`timescale 1ns/10ps
module apr_host (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Link
    apr_link_if.host link,
    // User side
    input wire logic start_req,
    input wire apr_pkg::apr_width_t width_mode,
    input wire logic msb16_only,
    input wire logic auto_read,
    output logic [apr_pkg::RES_W-1:0] result_o,
    output logic result_valid_o,
    output logic idle_o
);
    apr_pkg::apr_host_state_t state_q, state_d;
    apr_pkg::apr_width_t mode_q, mode_d;
    logic msb16_q, msb16_d;
    logic auto_q, auto_d;
    logic [apr_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [1:0] slice_q, slice_d;
    logic [1:0] last_slice;
    logic [apr_pkg::RES_W-1:0] acc_q, acc_d;
    logic [apr_pkg::RES_W-1:0] res_q, res_d;
    logic valid_q, valid_d;
    logic cs_n_q, cs_n_d;
    logic rd_n_q, rd_n_d;
    logic cst_n_q, cst_n_d;
    logic wws_q, wws_d;
    logic mss_q, mss_d;
    logic idle_q, idle_d;

    always_comb begin
        last_slice = 2'h0;
        unique case (mode_q)
            apr_pkg::APR_W18: last_slice = 2'h0;
            apr_pkg::APR_W16: last_slice = 2'h1;
            apr_pkg::APR_W8: last_slice = msb16_q ? 2'h1 : 2'h2;
            default: last_slice = 2'h0;
        endcase
    end

    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        msb16_d = msb16_q;
        auto_d = auto_q;
        cnt_d = cnt_q;
        slice_d = slice_q;
        acc_d = acc_q;
        res_d = res_q;
        valid_d = 1'b0;
        cs_n_d = cs_n_q;
        rd_n_d = rd_n_q;
        cst_n_d = cst_n_q;
        wws_d = wws_q;
        mss_d = mss_q;
        idle_d = 1'b0;
        unique case (state_q)
            apr_pkg::APR_H_IDLE: begin
                idle_d = ~start_req;
                if (start_req) begin
                    mode_d = width_mode;
                    msb16_d = msb16_only;
                    auto_d = auto_read;
                    cnt_d = apr_pkg::PRE_LOAD;
                    state_d = apr_pkg::APR_H_GAP;
                end
            end
            // No read near the start edge
            apr_pkg::APR_H_GAP: begin
                if (cnt_q == 3'h0) begin
                    cst_n_d = 1'b0;
                    cnt_d = apr_pkg::START_LOW_LAST;
                    state_d = apr_pkg::APR_H_START;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            apr_pkg::APR_H_START: begin
                if (cnt_q == 3'h0) begin
                    cst_n_d = 1'b1;
                    state_d = apr_pkg::APR_H_WAIT_BUSY;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            apr_pkg::APR_H_WAIT_BUSY: begin
                if (link.busy) begin
                    state_d = apr_pkg::APR_H_WAIT_DONE;
                end
            end
            // Busy fall marks a new result
            apr_pkg::APR_H_WAIT_DONE: begin
                if (!link.busy) begin
                    slice_d = 2'h0;
                    wws_d = 1'b0;
                    mss_d = 1'b0;
                    cs_n_d = 1'b0;
                    rd_n_d = 1'b0;
                    cnt_d = apr_pkg::SLICE_HOLD_LAST;
                    state_d = apr_pkg::APR_H_READ;
                end
            end
            apr_pkg::APR_H_READ: begin
                if (cnt_q != 3'h0) begin
                    cnt_d = cnt_q - 3'h1;
                end else begin
                    unique case (slice_q)
                        2'h0: begin
                            if (mode_q == apr_pkg::APR_W18) begin
                                acc_d = link.result_bus;
                            end else if (mode_q == apr_pkg::APR_W16) begin
                                acc_d[17:2] = link.result_bus[17:2];
                            end else begin
                                acc_d[17:10] = link.result_bus[17:10];
                            end
                        end
                        2'h1: begin
                            if (mode_q == apr_pkg::APR_W16) begin
                                acc_d[1:0] = link.result_bus[3:2];
                            end else begin
                                acc_d[9:2] = link.result_bus[17:10];
                            end
                        end
                        default: acc_d[1:0] = link.result_bus[11:10];
                    endcase
                    if (slice_q == 2'h0 && mode_q == apr_pkg::APR_W8 && msb16_q) begin
                        acc_d[1:0] = 2'h0;
                    end
                    if (slice_q == last_slice) begin
                        cs_n_d = 1'b1;
                        rd_n_d = 1'b1;
                        state_d = apr_pkg::APR_H_DONE;
                    end else begin
                        slice_d = slice_q + 2'h1;
                        wws_d = (mode_q == apr_pkg::APR_W16) || (slice_q == 2'h1);
                        mss_d = (mode_q == apr_pkg::APR_W8);
                        cnt_d = apr_pkg::SLICE_HOLD_LAST;
                        if (auto_q) begin
                            state_d = apr_pkg::APR_H_READ;
                        end else begin
                            rd_n_d = 1'b1;
                            state_d = apr_pkg::APR_H_TOGGLE;
                        end
                    end
                end
            end
            apr_pkg::APR_H_TOGGLE: begin
                rd_n_d = 1'b0;
                state_d = apr_pkg::APR_H_READ;
            end
            apr_pkg::APR_H_DONE: begin
                res_d = acc_q;
                valid_d = 1'b1;
                idle_d = 1'b1;
                state_d = apr_pkg::APR_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= apr_pkg::APR_H_IDLE;
            mode_q <= apr_pkg::APR_W18;
            msb16_q <= 1'b0;
            auto_q <= 1'b0;
            cnt_q <= 3'h0;
            slice_q <= 2'h0;
            acc_q <= apr_pkg::RESULT_RST;
            res_q <= apr_pkg::RESULT_RST;
            valid_q <= 1'b0;
            cs_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            cst_n_q <= 1'b1;
            wws_q <= 1'b0;
            mss_q <= 1'b0;
            idle_q <= 1'b1;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            msb16_q <= msb16_d;
            auto_q <= auto_d;
            cnt_q <= cnt_d;
            slice_q <= slice_d;
            acc_q <= acc_d;
            res_q <= res_d;
            valid_q <= valid_d;
            cs_n_q <= cs_n_d;
            rd_n_q <= rd_n_d;
            cst_n_q <= cst_n_d;
            wws_q <= wws_d;
            mss_q <= mss_d;
            idle_q <= idle_d;
        end
    end

    assign link.chip_select_n = cs_n_q;
    assign link.read_strobe_n = rd_n_q;
    assign link.conversion_start_n = cst_n_q;
    assign link.word_width_select = wws_q;
    assign link.middle_slice_select = mss_q;
    assign result_o = res_q;
    assign result_valid_o = valid_q;
    assign idle_o = idle_q;
endmodule : apr_host

// ===== hdl/apr_device.sv
// Purpose: Converter end of the parallel result read-out port
// Assumes: All link inputs synchronous to core_clk
// Notes: Pins follow strobes and selects one clock later
`timescale 1ns/10ps
module apr_device (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Link
    apr_link_if.dev link,
    // Converter side
    input wire logic signed [19:0] sample_in,
    output logic [apr_pkg::RES_W-1:0] result_o,
    output logic result_valid_o,
    output logic quiet_violation_o
);
    // Conversion state
    apr_pkg::apr_conv_state_t state_q, state_d;
    logic [apr_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic start_prev_q, start_prev_d;
    logic [apr_pkg::RES_W-1:0] held_q, held_d;
    logic [apr_pkg::RES_W-1:0] result_q, result_d;
    logic valid_q, valid_d;
    logic busy_q, busy_d;
    logic start_edge;
    logic [apr_pkg::RES_W-1:0] coded;

    // Read port state
    logic [apr_pkg::RES_W-1:0] bus_q, bus_d;
    logic [apr_pkg::RES_W-1:0] oe_q, oe_d;
    logic read_active;

    // Quiet zone watch
    logic [apr_pkg::CNT_W-1:0] pre_q, pre_d;
    logic [apr_pkg::CNT_W-1:0] post_q, post_d;
    logic viol_q, viol_d;

    assign start_edge = start_prev_q && !link.conversion_start_n;
    assign read_active = !link.chip_select_n && !link.read_strobe_n;

    // Sample to output code
    always_comb begin
        if (sample_in[19:17] == 3'h0 || sample_in[19:17] == 3'h7) begin
            coded = sample_in[17:0];
        end else if (sample_in[19]) begin
            coded = apr_pkg::CODE_NEG_MAX;
        end else begin
            coded = apr_pkg::CODE_POS_MAX;
        end
    end

    // Conversion sequencing
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        start_prev_d = link.conversion_start_n;
        held_d = held_q;
        result_d = result_q;
        valid_d = 1'b0;
        busy_d = busy_q;
        unique case (state_q)
            apr_pkg::APR_CONV_IDLE: begin
                if (start_edge) begin
                    held_d = coded;
                    cnt_d = apr_pkg::CONV_LAST;
                    busy_d = 1'b1;
                    state_d = apr_pkg::APR_CONV_RUN;
                end
            end
            apr_pkg::APR_CONV_RUN: begin
                if (cnt_q == 3'h0) begin
                    result_d = held_q;
                    valid_d = 1'b1;
                    busy_d = 1'b0;
                    state_d = apr_pkg::APR_CONV_IDLE;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= apr_pkg::APR_CONV_IDLE;
            cnt_q <= 3'h0;
            start_prev_q <= 1'b1;
            held_q <= apr_pkg::RESULT_RST;
            result_q <= apr_pkg::RESULT_RST;
            valid_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            start_prev_q <= start_prev_d;
            held_q <= held_d;
            result_q <= result_d;
            valid_q <= valid_d;
            busy_q <= busy_d;
        end
    end

    // Slice steering from current selects
    always_comb begin
        bus_d = apr_pkg::ALL_ONES;
        unique case ({link.word_width_select, link.middle_slice_select})
            2'b00: bus_d = result_q;
            2'b10: bus_d[3:2] = result_q[1:0];
            2'b01: bus_d[17:10] = result_q[9:2];
            2'b11: bus_d[11:10] = result_q[1:0];
        endcase
        oe_d = read_active ? apr_pkg::ALL_ONES : apr_pkg::CODE_ZERO;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_q <= apr_pkg::ALL_ONES;
            oe_q <= apr_pkg::CODE_ZERO;
        end else begin
            bus_q <= bus_d;
            oe_q <= oe_d;
        end
    end

    // Reads close to a start edge
    always_comb begin
        pre_d = pre_q;
        post_d = post_q;
        if (read_active) begin
            pre_d = apr_pkg::PRE_LOAD;
        end else if (pre_q != 3'h0) begin
            pre_d = pre_q - 3'h1;
        end
        if (start_edge) begin
            post_d = apr_pkg::POST_LOAD;
        end else if (post_q != 3'h0) begin
            post_d = post_q - 3'h1;
        end
        viol_d = (start_edge && pre_q != 3'h0) ||
            (read_active && (start_edge || post_q != 3'h0));
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= 3'h0;
            post_q <= 3'h0;
            viol_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            post_q <= post_d;
            viol_q <= viol_d;
        end
    end

    assign link.busy = busy_q;
    assign link.result_bus_o = bus_q;
    assign link.result_bus_oe = oe_q;
    assign result_o = result_q;
    assign result_valid_o = valid_q;
    assign quiet_violation_o = viol_q;
endmodule : apr_device

// ===== test/apr_link_props.sv
// Purpose: Checks on the link between converter end and host end
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Takes the interface signals as plain inputs
`timescale 1ns/10ps
module apr_link_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Link
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic conversion_start_n,
    input wire logic word_width_select,
    input wire logic middle_slice_select,
    input wire logic busy,
    input wire logic [apr_pkg::RES_W-1:0] result_bus_o,
    input wire logic [apr_pkg::RES_W-1:0] result_bus_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    logic [apr_pkg::RES_W-1:0] bus_prev_q;
    logic rd_on;
    assign rd_on = !chip_select_n && !read_strobe_n;
    // Last driven data, for slice comparisons
    always_ff @(posedge core_clk) begin
        bus_prev_q <= result_bus_o;
    end

    sequence s_full;
        rd_on && !word_width_select && !middle_slice_select;
    endsequence
    sequence s_ww;
        rd_on && word_width_select && !middle_slice_select;
    endsequence
    sequence s_ms;
        rd_on && !word_width_select && middle_slice_select;
    endsequence
    sequence s_both;
        rd_on && word_width_select && middle_slice_select;
    endsequence

    a_bus_released: assert property (!rd_on |=> result_bus_oe == '0)
        else $error("bus driven outside a read");
    a_bus_driven: assert property (rd_on |=> result_bus_oe == '1)
        else $error("bus not driven during a read");
    a_ww_fill: assert property (s_ww |=> result_bus_o[17:4] == 14'h3fff &&
        result_bus_o[1:0] == 2'h3) else $error("width slice filler wrong");
    a_ms_fill: assert property (s_ms |=> result_bus_o[9:0] == 10'h3ff)
        else $error("middle slice filler wrong");
    a_both_fill: assert property (s_both |=> result_bus_o[17:12] == 6'h3f &&
        result_bus_o[9:0] == 10'h3ff) else $error("low slice filler wrong");
    a_ww_follow: assert property (s_full ##1 s_ww |=>
        result_bus_o[3:2] == bus_prev_q[1:0]) else $error("low bits not on pins 3..2");
    a_ms_follow: assert property (s_full ##1 s_ms |=>
        result_bus_o[17:10] == bus_prev_q[9:2]) else $error("middle bits misplaced");
    a_start_busy: assert property ($fell(conversion_start_n) && !busy |=> busy)
        else $error("start edge not taken");
    a_busy_span: assert property ($rose(busy) |-> busy[*6] ##1 !busy)
        else $error("conversion length wrong");
endmodule : apr_link_props

// ===== test/tb.sv
// Purpose: Self-checking bench for the parallel result read-out port
// Assumes: Host and converter ends joined by one link
// Notes: A second converter end is driven by hand for slices and quiet zone
`timescale 1ns/10ps
module tb;
    typedef struct {
        logic [19:0] smp;
        apr_pkg::apr_width_t mode;
        logic msb;
        logic aut;
        logic [17:0] code;
        logic [17:0] host;
    } apr_row_t;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic start_req = 1'b0;
    apr_pkg::apr_width_t width_mode = apr_pkg::APR_W18;
    logic msb16_only = 1'b0;
    logic auto_read = 1'b0;
    logic [19:0] smp_a = 20'h00000;
    logic [19:0] smp_b = 20'h1a5c3;
    logic [17:0] host_res, dev_res, dev_res_b;
    logic host_vld, host_idle, dev_vld, dev_vld_b, qv_a, qv_b;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int qv_a_cnt = 0;
    int qv_b_cnt = 0;
    int vld_a_cnt = 0;
    apr_row_t rows [7];

    apr_link_if u_apr_link_if ();
    apr_link_if lk_b ();
    apr_host u_apr_host (.core_clk, .arst_n, .link(u_apr_link_if.host), .start_req,
        .width_mode, .msb16_only, .auto_read, .result_o(host_res),
        .result_valid_o(host_vld), .idle_o(host_idle));
    apr_device u_apr_device (.core_clk, .arst_n, .link(u_apr_link_if.dev), .sample_in(smp_a),
        .result_o(dev_res), .result_valid_o(dev_vld), .quiet_violation_o(qv_a));
    apr_device u_apr_device_b (.core_clk, .arst_n, .link(lk_b.dev), .sample_in(smp_b),
        .result_o(dev_res_b), .result_valid_o(dev_vld_b), .quiet_violation_o(qv_b));
    apr_link_props u_apr_link_props (.core_clk, .arst_n,
        .chip_select_n(u_apr_link_if.chip_select_n),
        .read_strobe_n(u_apr_link_if.read_strobe_n),
        .conversion_start_n(u_apr_link_if.conversion_start_n),
        .word_width_select(u_apr_link_if.word_width_select),
        .middle_slice_select(u_apr_link_if.middle_slice_select),
        .busy(u_apr_link_if.busy), .result_bus_o(u_apr_link_if.result_bus_o),
        .result_bus_oe(u_apr_link_if.result_bus_oe));

    always #50 core_clk = ~core_clk;
    // Cycle ceiling and quiet-zone pulse counts
    always @(posedge core_clk) begin
        cyc++;
        if (qv_a === 1'b1) qv_a_cnt++;
        if (qv_b === 1'b1) qv_b_cnt++;
        if (dev_vld === 1'b1) vld_a_cnt++;
        if (cyc == 4000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic print_verdict();
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // Pins expected for one slice selection
    function automatic logic [17:0] exp_bus(input logic [17:0] c, input logic ww,
        input logic ms);
        case ({ms, ww})
            2'h0: return c;
            2'h1: return {14'h3fff, c[1:0], 2'h3};
            2'h2: return {c[9:2], 10'h3ff};
            default: return {6'h3f, c[1:0], 10'h3ff};
        endcase
    endfunction : exp_bus

    task automatic do_reset();
        @(negedge core_clk);
        arst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        chk("busy", u_apr_link_if.busy, 18'h0);
        chk("oe", u_apr_link_if.result_bus_oe, 18'h0);
        chk("idle", host_idle, 18'h1);
        chk("reset result", dev_res, 18'h0);
        @(negedge core_clk);
        arst_n = 1'b1;
    endtask : do_reset

    task automatic run_row(input apr_row_t r);
        int k;
        @(negedge core_clk);
        smp_a = r.smp;
        width_mode = r.mode;
        msb16_only = r.msb;
        auto_read = r.aut;
        start_req = 1'b1;
        @(negedge core_clk);
        start_req = 1'b0;
        for (k = 0; k < 60 && host_vld !== 1'b1; k++) @(negedge core_clk);
        chk("host valid", host_vld, 18'h1);
        chk("host result", host_res, r.host);
        chk("device result", dev_res, r.code);
        chk("idle", host_idle, 18'h1);
    endtask : run_row

    initial begin
        lk_b.chip_select_n = 1'b1;
        lk_b.read_strobe_n = 1'b1;
        lk_b.conversion_start_n = 1'b1;
        lk_b.word_width_select = 1'b0;
        lk_b.middle_slice_select = 1'b0;
        rows = '{
            '{20'h00000, apr_pkg::APR_W18, 1'b0, 1'b0, 18'h00000, 18'h00000},
            '{20'hfffff, apr_pkg::APR_W16, 1'b0, 1'b1, 18'h3ffff, 18'h3ffff},
            '{20'h1ffff, apr_pkg::APR_W8, 1'b0, 1'b0, 18'h1ffff, 18'h1ffff},
            '{20'he0000, apr_pkg::APR_W8, 1'b0, 1'b1, 18'h20000, 18'h20000},
            '{20'h30d40, apr_pkg::APR_W18, 1'b0, 1'b1, 18'h1ffff, 18'h1ffff},
            '{20'h12345, apr_pkg::APR_W8, 1'b1, 1'b1, 18'h12345, 18'h12344},
            '{20'hb6c20, apr_pkg::APR_W16, 1'b0, 1'b0, 18'h20000, 18'h20000}
        };
        do_reset();
        foreach (rows[i]) run_row(rows[i]);
        chk("host quiet pulses", 18'(qv_a_cnt), 18'h0);
        chk("device valid pulses", 18'(vld_a_cnt), 18'h7);
        // Hand-driven converter: conversion, then every slice with strobe held low
        @(negedge core_clk);
        lk_b.conversion_start_n = 1'b0;
        @(negedge core_clk);
        lk_b.conversion_start_n = 1'b1;
        repeat (6) @(negedge core_clk);
        chk("b valid", dev_vld_b, 18'h1);
        chk("b result", dev_res_b, 18'h1a5c3);
        lk_b.chip_select_n = 1'b0;
        lk_b.read_strobe_n = 1'b0;
        for (int s = 0; s < 4; s++) begin
            lk_b.word_width_select = s[0];
            lk_b.middle_slice_select = s[1];
            repeat (2) @(negedge core_clk);
            chk("slice", lk_b.result_bus, exp_bus(18'h1a5c3, s[0], s[1]));
        end
        for (int c = 1; c < 4; c++) begin
            lk_b.chip_select_n = c[1];
            lk_b.read_strobe_n = c[0];
            repeat (2) @(negedge core_clk);
            chk("released", lk_b.result_bus_oe, 18'h0);
        end
        // Read on the start edge
        lk_b.chip_select_n = 1'b0;
        lk_b.read_strobe_n = 1'b0;
        lk_b.conversion_start_n = 1'b0;
        @(negedge core_clk);
        chk("served", lk_b.result_bus, exp_bus(18'h1a5c3, 1'b1, 1'b1));
        lk_b.chip_select_n = 1'b1;
        lk_b.read_strobe_n = 1'b1;
        lk_b.conversion_start_n = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("quiet flag", 18'(qv_b_cnt != 0), 18'h1);
        // Reset in mid-conversion, before any slice is read, then recovery
        @(negedge core_clk);
        start_req = 1'b1;
        @(negedge core_clk);
        start_req = 1'b0;
        repeat (5) @(negedge core_clk);
        do_reset();
        run_row(rows[3]);
        print_verdict();
    end
endmodule : tb
